// [design/pgc_pkg.sv]
// Package with the register map, gate bit positions and types of the block.
package pgc_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [11:0] ANALOG_OFS   = 12'h240;
  localparam logic [11:0] COMP_OFS     = 12'h250;
  localparam logic [11:0] CAPCMP_OFS   = 12'h260;
  localparam logic [11:0] TIMER_OFS    = 12'h270;
  localparam logic [11:0] SERIAL_OFS   = 12'h280;
  localparam logic [11:0] MISC_OFS     = 12'h290;
  localparam logic [11:0] LOCK_OFS     = 12'h2A0;
  localparam logic [11:0] KEY_OFS      = 12'h2B0;
  localparam logic [11:0] GATE_SPAN    = 12'h060;
  localparam int          NUM_GATE_REG = 6;

  // Alias selectors held in address bits 3:2.
  localparam logic [1:0] ALIAS_RW  = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // Analog gate register fields.
  localparam int ADC_GATE_BIT        = 0;
  localparam int CHARGE_TIME_BIT     = 8;
  localparam int CMP_VREF_BIT        = 12;
  localparam int VOLT_DETECT_BIT     = 20;
  // Comparator gate register fields, three units from this bit up.
  localparam int COMPARATOR1_BIT     = 0;
  localparam int NUM_COMPARATOR      = 3;
  // Capture and compare fields, five units each.
  localparam int CAPTURE1_BIT        = 0;
  localparam int COMPARE1_BIT        = 16;
  localparam int NUM_CAPCMP          = 5;
  // Timer fields, five timers.
  localparam int TIMER1_BIT          = 0;
  localparam int NUM_TIMER           = 5;
  // Serial gate register fields.
  localparam int UART1_BIT           = 0;
  localparam int SPI1_BIT            = 8;
  localparam int I2C_FIRST_BIT       = 16;
  localparam int USB_GATE_BIT        = 24;
  // Miscellaneous gate register fields.
  localparam int CALENDAR_BIT        = 0;
  localparam int REFCLK_OUT_BIT      = 1;
  localparam int PARALLEL_PORT_BIT   = 16;

  // Implemented bit masks; everything else reads as zero.
  localparam logic [31:0] ANALOG_MASK = (32'h1 << ADC_GATE_BIT)
    | (32'h1 << CHARGE_TIME_BIT) | (32'h1 << CMP_VREF_BIT)
    | (32'h1 << VOLT_DETECT_BIT);
  localparam logic [31:0] COMP_MASK   = 32'h7 << COMPARATOR1_BIT;
  localparam logic [31:0] CAPCMP_MASK = (32'h1F << CAPTURE1_BIT)
    | (32'h1F << COMPARE1_BIT);
  localparam logic [31:0] TIMER_MASK  = 32'h1F << TIMER1_BIT;
  localparam logic [31:0] SERIAL_MASK = (32'h3 << UART1_BIT)
    | (32'h3 << SPI1_BIT) | (32'h3 << I2C_FIRST_BIT)
    | (32'h1 << USB_GATE_BIT);
  localparam logic [31:0] MISC_MASK   = (32'h1 << CALENDAR_BIT)
    | (32'h1 << REFCLK_OUT_BIT) | (32'h1 << PARALLEL_PORT_BIT);

  // Reset value of every gate register: all peripherals clocked.
  localparam logic [31:0] GATE_RST    = 32'h0000_0000;

  // Lock register fields.
  localparam int LOCK_BIT    = 0;
  localparam int ONE_WAY_BIT = 1;

  // Unlock key pair, values arbitrary.
  localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;

  // Strap settle count after reset release.
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // One bit per gate position, grouped by register; bit 1 means gated.
  typedef struct packed {
    logic [31:0] misc;
    logic [31:0] serial;
    logic [31:0] timer;
    logic [31:0] capcmp;
    logic [31:0] comp;
    logic [31:0] analog;
  } pgc_gates_t;

  // Avalon-MM request from the system bus.
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pgc_avm_req_t;

endpackage

// [design/pgc_gate_cell.sv]
// Per-peripheral clock enable and register access gating.
`timescale 1ns/1ps
module pgc_gate_cell import pgc_pkg::*; #(
  parameter int W = 192
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Gate bits from the register file.
  input  wire logic [W-1:0] gate_in,
  // Clock enable sources and register strobes of each peripheral.
  input  wire logic [W-1:0] tick_in,
  input  wire logic [W-1:0] wr_in,
  input  wire logic [W-1:0] rd_in,
  // Gated enables and strobes towards each peripheral.
  output logic [W-1:0]      clk_en_out,
  output logic [W-1:0]      wr_en_out,
  output logic [W-1:0]      rd_valid_out
);

  typedef struct packed {
    logic [W-1:0] gate;
  } pgc_cell_state_t;

  pgc_cell_state_t st;
  pgc_cell_state_t next_st;

  // Registered copy of the gate bits.
  always_comb begin
    next_st      = st;
    next_st.gate = gate_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st.gate <= '0;
    end else begin
      st <= next_st;
    end
  end

  // gated peripherals lose every clock enable, cleared ones regain it.
  assign clk_en_out   = tick_in & ~st.gate;
  // writes to a gated peripheral are dropped and reads flagged invalid.
  assign wr_en_out    = wr_in & ~st.gate;
  assign rd_valid_out = rd_in & ~st.gate;

  property p_gate_stop;
    @(posedge clk_in) disable iff (!rstn_in)
      (gate_in != '0) |=> ((clk_en_out & $past(gate_in)) == '0);
  endproperty
  a_gate_stop: assert property (p_gate_stop)
    else $error("Gated peripheral still receives a clock enable.");

  property p_write_blocked;
    @(posedge clk_in) disable iff (!rstn_in)
      ##1 (wr_en_out == (wr_in & ~$past(gate_in)))
          && (rd_valid_out == (rd_in & ~$past(gate_in)));
  endproperty
  a_write_blocked: assert property (p_write_blocked)
    else $error("Access reached a gated peripheral.");

  property p_ungate;
    @(posedge clk_in) disable iff (!rstn_in)
      (gate_in == '0) ##1 (gate_in == '0) |-> (clk_en_out == tick_in);
  endproperty
  a_ungate: assert property (p_ungate)
    else $error("Ungated peripheral lost its clock enable.");

endmodule

// [design/pgc_gate_ctrl.sv]
// Peripheral clock gate register file with Avalon-MM slave and lock.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module pgc_gate_ctrl import pgc_pkg::*; #(
  parameter logic [31:0] ANALOG_PRESENT = ANALOG_MASK,
  parameter logic [31:0] COMP_PRESENT   = COMP_MASK,
  parameter logic [31:0] CAPCMP_PRESENT = CAPCMP_MASK,
  parameter logic [31:0] TIMER_PRESENT  = TIMER_MASK,
  parameter logic [31:0] SERIAL_PRESENT = SERIAL_MASK,
  parameter logic [31:0] MISC_PRESENT   = MISC_MASK
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Avalon-MM slave.
  input  wire logic [11:0]  avs_address_in,
  input  wire logic         avs_read_in,
  input  wire logic         avs_write_in,
  input  wire logic [31:0]  avs_writedata_in,
  input  wire logic [3:0]   avs_byteenable_in,
  output logic [31:0]       avs_readdata_out,
  output logic              avs_waitrequest_out,
  // One-way lock strap pin.
  input  wire logic         gate_lock_one_way_in,
  // Peripheral side enables and strobes.
  input  wire pgc_gates_t   periph_tick_in,
  input  wire pgc_gates_t   periph_wr_in,
  input  wire pgc_gates_t   periph_rd_in,
  output pgc_gates_t        periph_clk_en_out,
  output pgc_gates_t        periph_wr_en_out,
  output pgc_gates_t        periph_rd_valid_out,
  // Status towards the system.
  output pgc_gates_t        gates_out,
  output logic              gate_write_lock_out
);

  localparam logic [NUM_GATE_REG-1:0][31:0] PRESENT = {MISC_PRESENT,
    SERIAL_PRESENT, TIMER_PRESENT, CAPCMP_PRESENT, COMP_PRESENT,
    ANALOG_PRESENT};

  typedef struct packed {
    logic [NUM_GATE_REG-1:0][31:0] gates;
    logic                          lock;
    logic                          one_way;
    logic                          strap_done;
    logic [2:0]                    strap_sync;
    logic [1:0]                    settle;
    logic [1:0]                    key_stage;
    logic                          ack;
    logic [31:0]                   rdata;
  } pgc_state_t;

  pgc_state_t   st;
  pgc_state_t   next_st;
  pgc_avm_req_t req;
  logic         gate_hit;
  logic [2:0]   gate_idx;
  logic [1:0]   alias_op;
  logic [31:0]  be_mask;
  logic         do_write;
  logic [31:0]  cur_word;
  logic [31:0]  lock_word;

  // True when the address falls inside the gate register window.
  function automatic logic in_gate_window(input logic [11:0] addr);
    return (addr >= ANALOG_OFS) && (addr < (ANALOG_OFS + GATE_SPAN));
  endfunction

  // Register index of a gate register address.
  function automatic logic [2:0] gate_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - ANALOG_OFS;
    return rel[6:4];
  endfunction

  // Applies a plain, clear, set or invert write to a register word.
  function automatic logic [31:0] alias_apply(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [31:0] bmask,
    input logic [1:0]  op
  );
    logic [31:0] res;
    res = old;
    case (op)
      ALIAS_RW:  res = (old & ~bmask) | (wdata & bmask);
      ALIAS_CLR: res = old & ~(wdata & bmask);
      ALIAS_SET: res = old | (wdata & bmask);
      ALIAS_INV: res = old ^ (wdata & bmask);
      default:   res = old;
    endcase
    return res;
  endfunction

  // Gather the bus request and decode it.
  always_comb begin
    req.address    = avs_address_in;
    req.read       = avs_read_in;
    req.write      = avs_write_in;
    req.writedata  = avs_writedata_in;
    req.byteenable = avs_byteenable_in;
    gate_hit       = in_gate_window(req.address)
                     && (gate_index(req.address) < 3'(NUM_GATE_REG));
    gate_idx       = gate_index(req.address);
    alias_op       = req.address[3:2];
    be_mask        = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                      {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    do_write       = req.write && st.ack;
    cur_word       = gate_hit ? st.gates[gate_idx] : 32'h0000_0000;
    lock_word      = alias_apply({31'h0, st.lock}, req.writedata,
                                 32'h0000_0001 << LOCK_BIT, alias_op);
  end

  // One wait cycle, then the access completes.
  assign avs_waitrequest_out = (req.read || req.write) && !st.ack;
  assign avs_readdata_out    = st.rdata;

  // Next state of the register file, lock and bus handshake.
  always_comb begin
    next_st            = st;
    next_st.strap_sync = {st.strap_sync[1:0], gate_lock_one_way_in};
    // Strap is caught once after reset, when the synchroniser agrees.
    if (!st.strap_done) begin
      if (st.settle != STRAP_SETTLE) begin
        next_st.settle = st.settle + 2'h1;
      end else if (st.strap_sync[1] == st.strap_sync[2]) begin
        next_st.one_way    = st.strap_sync[2];
        next_st.strap_done = 1'b1;
      end
    end
    // Acknowledge strobe toggles so every request waits exactly once.
    next_st.ack = (req.read || req.write) && !st.ack;
    // Read data is captured on the first cycle and stands at completion.
    if (req.read && !st.ack) begin
      if (gate_hit) begin
        next_st.rdata = cur_word;
      end else if ((req.address & ~12'h00C) == LOCK_OFS) begin
        next_st.rdata = 32'h0000_0000;
        next_st.rdata[LOCK_BIT]    = st.lock;
        next_st.rdata[ONE_WAY_BIT] = st.one_way;
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
    if (do_write) begin
      if (gate_hit) begin
        // a locked register accepts the write but keeps its value.
        if (!st.lock) begin
          // aliases clear, set or toggle the written ones.
          // only implemented, present bits ever take a value.
          // bit positions fixed by the present masks.
          next_st.gates[gate_idx] = alias_apply(st.gates[gate_idx],
            req.writedata, be_mask, alias_op) & PRESENT[gate_idx];
        end
      end else if (req.address == KEY_OFS) begin
        // Unlock key pair arms exactly one lock register write.
        if (st.key_stage == 2'h0 && req.writedata == UNLOCK_KEY1) begin
          next_st.key_stage = 2'h1;
        end else if (st.key_stage == 2'h1
                     && req.writedata == UNLOCK_KEY2) begin
          next_st.key_stage = 2'h2;
        end else begin
          next_st.key_stage = 2'h0;
        end
      end else if ((req.address & ~12'h00C) == LOCK_OFS) begin
        next_st.key_stage = 2'h0;
        if (st.key_stage == 2'h2 && req.byteenable[0]) begin
          // with the one-way strap a set lock cannot be cleared.
          next_st.lock = lock_word[LOCK_BIT] | (st.lock && st.one_way);
        end
      end else begin
        next_st.key_stage = 2'h0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // every gate starts cleared so all peripherals run.
      st.gates      <= {NUM_GATE_REG{GATE_RST}};
      st.lock       <= 1'b0;
      st.one_way    <= 1'b0;
      st.strap_done <= 1'b0;
      st.strap_sync <= 3'h0;
      st.settle     <= 2'h0;
      st.key_stage  <= 2'h0;
      st.ack        <= 1'b0;
      st.rdata      <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Status outputs taken straight from the state register.
  assign gates_out           = pgc_gates_t'(st.gates);
  assign gate_write_lock_out = st.lock;

  // gate bits drive the per-peripheral enables and strobes.
  pgc_gate_cell #(
    .W (32 * NUM_GATE_REG)
  ) u_cell (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .gate_in      (st.gates),
    .tick_in      (periph_tick_in),
    .wr_in        (periph_wr_in),
    .rd_in        (periph_rd_in),
    .clk_en_out   (periph_clk_en_out),
    .wr_en_out    (periph_wr_en_out),
    .rd_valid_out (periph_rd_valid_out)
  );

  property p_unimpl_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.gates & ~PRESENT) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented gate bit holds a one.");

  property p_locked_stable;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && gate_hit && st.lock) |=> $stable(st.gates);
  endproperty
  a_locked_stable: assert property (p_locked_stable)
    else $error("Locked gate register changed on a write.");

  property p_one_way_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.lock && st.one_way) |=> st.lock [*3];
  endproperty
  a_one_way_hold: assert property (p_one_way_hold)
    else $error("One-way lock was released.");

  property p_set_alias;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && gate_hit && !st.lock && alias_op == ALIAS_SET
       && req.byteenable == 4'hF)
      |=> ((st.gates[$past(gate_idx)] & $past(req.writedata)
            & PRESENT[$past(gate_idx)])
           == ($past(req.writedata) & PRESENT[$past(gate_idx)]));
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("Set alias did not set the written bits.");

  property p_clr_alias;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && gate_hit && !st.lock && alias_op == ALIAS_CLR
       && req.byteenable == 4'hF)
      |=> ((st.gates[$past(gate_idx)] & $past(req.writedata)) == '0);
  endproperty
  a_clr_alias: assert property (p_clr_alias)
    else $error("Clear alias left a written bit set.");

  property p_usb_pos;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && req.address == SERIAL_OFS && !st.lock
       && req.byteenable == 4'hF)
      |=> (gates_out.serial[USB_GATE_BIT]
           == ($past(req.writedata[USB_GATE_BIT])
               && SERIAL_PRESENT[USB_GATE_BIT]));
  endproperty
  a_usb_pos: assert property (p_usb_pos)
    else $error("Serial gate USB bit not at its position.");

  property p_adc_clock;
    @(posedge clk_in) disable iff (!rstn_in)
      gates_out.analog[ADC_GATE_BIT]
      ##1 gates_out.analog[ADC_GATE_BIT]
      |-> !periph_clk_en_out.analog[ADC_GATE_BIT];
  endproperty
  a_adc_clock: assert property (p_adc_clock)
    else $error("ADC clock runs while its gate is set.");

  property p_wait_once;
    @(posedge clk_in) disable iff (!rstn_in)
      ((avs_read_in || avs_write_in) && avs_waitrequest_out)
      |=> !avs_waitrequest_out;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("Bus access waited more than one cycle.");

  // Plain full-width writes keep only the implemented bits.
  property p_plain_write;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && gate_hit && !st.lock && alias_op == ALIAS_RW
       && req.byteenable == 4'hF)
      |=> (st.gates[$past(gate_idx)]
           == ($past(req.writedata) & PRESENT[$past(gate_idx)]));
  endproperty
  a_plain_write: assert property (p_plain_write)
    else $error("Plain gate write did not store the written bits.");

  // Invert writes toggle exactly the written, implemented bits.
  property p_inv_alias;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && gate_hit && !st.lock && alias_op == ALIAS_INV
       && req.byteenable == 4'hF)
      |=> (st.gates[$past(gate_idx)]
           == ($past(cur_word) ^ ($past(req.writedata)
               & PRESENT[$past(gate_idx)])));
  endproperty
  a_inv_alias: assert property (p_inv_alias)
    else $error("Invert alias did not toggle the written bits.");

  // The strap is caught once and then stays put until reset.
  property p_strap_once;
    @(posedge clk_in) disable iff (!rstn_in)
      st.strap_done |=> (st.strap_done && $stable(st.one_way));
  endproperty
  a_strap_once: assert property (p_strap_once)
    else $error("One-way strap changed after it was caught.");

  // A lock write without the armed key pair leaves the lock alone.
  property p_unarmed_lock;
    @(posedge clk_in) disable iff (!rstn_in)
      (do_write && (req.address & ~12'h00C) == LOCK_OFS
       && st.key_stage != 2'h2) |=> $stable(st.lock);
  endproperty
  a_unarmed_lock: assert property (p_unarmed_lock)
    else $error("Lock bit changed without the unlock key pair.");

  // Read data captured for a request stands until the next read.
  property p_rdata_stands;
    @(posedge clk_in) disable iff (!rstn_in)
      !(avs_read_in && !st.ack) |=> $stable(avs_readdata_out);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("Read data changed without a new read request.");

endmodule

// [testbench/pgc_gate_ctrl_bench.sv]
// Self-checking bench for the peripheral clock gate register block.
`timescale 1ns/1ps
module pgc_gate_ctrl_bench import pgc_pkg::*;
;
  localparam int CYCLE_LIMIT = 4000;

  // Design stimulus and observed outputs.
  logic        clk_in;
  logic        rstn_in;
  logic [11:0] address;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        strap;
  logic        lock_out;
  pgc_gates_t  tick;
  pgc_gates_t  pwr;
  pgc_gates_t  prd;
  pgc_gates_t  clk_en;
  pgc_gates_t  wr_en;
  pgc_gates_t  rd_valid;
  pgc_gates_t  gates;
  // Bench bookkeeping and expected register contents.
  int          miscompares;
  int          checks;
  int          cycles;
  logic [31:0] gexp [6];
  logic [31:0] impl [6];
  logic [11:0] ofs  [6];

  pgc_gate_ctrl u_pgc_gate_ctrl (
    .clk_in               (clk_in),
    .rstn_in              (rstn_in),
    .avs_address_in       (address),
    .avs_read_in          (rd),
    .avs_write_in         (wr),
    .avs_writedata_in     (wdata),
    .avs_byteenable_in    (be),
    .avs_readdata_out     (rdata),
    .avs_waitrequest_out  (waitreq),
    .gate_lock_one_way_in (strap),
    .periph_tick_in       (tick),
    .periph_wr_in         (pwr),
    .periph_rd_in         (prd),
    .periph_clk_en_out    (clk_en),
    .periph_wr_en_out     (wr_en),
    .periph_rd_valid_out  (rd_valid),
    .gates_out            (gates),
    .gate_write_lock_out  (lock_out)
  );

  // Free running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles >= CYCLE_LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [191:0] seen, input logic [191:0] expd);
    checks++;
    if (seen !== expd) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low.
  task automatic bus_op(input logic is_wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] b,
                        output logic [31:0] q);
    logic done;
    done = 1'b0;
    q = 32'h0;
    @(posedge clk_in);
    address <= a;
    wdata <= d;
    be <= b;
    wr <= is_wr;
    rd <= !is_wr;
    // Waitrequest and read data are taken at the same rising edge.
    while (!done) begin
      @(posedge clk_in);
      done = (waitreq === 1'b0);
      q = rdata;
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] b);
    logic [31:0] q;
    bus_op(1'b1, a, d, b, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] expd);
    logic [31:0] q;
    bus_op(1'b0, a, 32'h0, 4'hF, q);
    check(192'(q), 192'(expd));
  endtask

  task automatic unlock();
    wr_reg(KEY_OFS, UNLOCK_KEY1, 4'hF);
    wr_reg(KEY_OFS, UNLOCK_KEY2, 4'hF);
  endtask

  // Reads every gate register and checks the peripheral side gating.
  task automatic check_all();
    logic [191:0] g;
    g = {gexp[5], gexp[4], gexp[3], gexp[2], gexp[1], gexp[0]};
    for (int i = 0; i < 6; i++) begin
      rd_chk(ofs[i], gexp[i]);
    end
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check(gates, g);
    check(clk_en, tick & ~g);
    check(wr_en, pwr & ~g);
    check(rd_valid, prd & ~g);
  endtask

  // Asynchronous reset held for 12 cycles, then strap settle time.
  task automatic do_reset(input logic one_way);
    if (rstn_in) begin
      @(posedge clk_in);
    end
    strap <= one_way;
    rstn_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    for (int i = 0; i < 6; i++) begin
      gexp[i] = 32'h0;
    end
  endtask

  // Main sequence.
  initial begin
    clk_in = 1'b0;
    rstn_in = 1'b0;
    address = 12'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    strap = 1'b0;
    tick = {6{32'hFFFF_FFFF}};
    pwr = {6{32'hFFFF_00FF}};
    prd = {6{32'h0F0F_F0F0}};
    miscompares = 0;
    checks = 0;
    cycles = 0;
    ofs = '{ANALOG_OFS, COMP_OFS, CAPCMP_OFS, TIMER_OFS, SERIAL_OFS,
            MISC_OFS};
    impl = '{32'h0010_1101, 32'h0000_0007, 32'h001F_001F, 32'h0000_001F,
             32'h0103_0303, 32'h0001_0003};
    do_reset(1'b0);
    check_all();
    rd_chk(LOCK_OFS, 32'h0000_0000);
    // All ones into every register: only assigned positions hold.
    for (int i = 0; i < 6; i++) begin
      wr_reg(ofs[i], 32'hFFFF_FFFF, 4'hF);
      gexp[i] = impl[i];
    end
    check_all();
    // Clearing every gate brings all clocks back.
    for (int i = 0; i < 6; i++) begin
      wr_reg(ofs[i], 32'h0000_0000, 4'hF);
      gexp[i] = 32'h0;
    end
    check_all();
    // Clear, set and invert aliases on the timer register.
    wr_reg(TIMER_OFS, 32'h0000_001F, 4'hF);
    wr_reg(TIMER_OFS + 12'h4, 32'h0000_0003, 4'hF);
    rd_chk(TIMER_OFS, 32'h0000_001C);
    wr_reg(TIMER_OFS + 12'h8, 32'h0000_0001, 4'hF);
    rd_chk(TIMER_OFS, 32'h0000_001D);
    wr_reg(TIMER_OFS + 12'hC, 32'hFFFF_FFFF, 4'hF);
    gexp[3] = 32'h0000_0002;
    rd_chk(TIMER_OFS, gexp[3]);
    // software has switched the USB unit off and let it idle.
    wr_reg(SERIAL_OFS + 12'h8, 32'h0100_0000, 4'hF);
    gexp[4] = 32'h0100_0000;
    check_all();
    // Only byte lane 0 is written.
    wr_reg(SERIAL_OFS, 32'hFFFF_FFFF, 4'h1);
    gexp[4] = 32'h0100_0003;
    rd_chk(SERIAL_OFS, gexp[4]);
    // Unmapped places read zero and writes there change nothing.
    wr_reg(12'h2C0, 32'hFFFF_FFFF, 4'hF);
    wr_reg(12'h000, 32'hFFFF_FFFF, 4'hF);
    rd_chk(12'h2C0, 32'h0000_0000);
    rd_chk(12'h000, 32'h0000_0000);
    check_all();
    // Lock write without the key is ignored.
    wr_reg(LOCK_OFS, 32'h0000_0001, 4'hF);
    rd_chk(LOCK_OFS, 32'h0000_0000);
    unlock();
    wr_reg(LOCK_OFS, 32'h0000_0001, 4'hF);
    @(negedge clk_in);
    check(192'(lock_out), 192'(1'b1));
    // While locked, plain and set writes leave the gates unchanged.
    for (int i = 0; i < 6; i++) begin
      wr_reg(ofs[i], 32'hFFFF_FFFF, 4'hF);
      wr_reg(ofs[i] + 12'h8, 32'hFFFF_FFFF, 4'hF);
    end
    check_all();
    // Without the one-way strap the lock can be cleared again.
    unlock();
    wr_reg(LOCK_OFS, 32'h0000_0000, 4'hF);
    rd_chk(LOCK_OFS, 32'h0000_0000);
    wr_reg(ANALOG_OFS, 32'hFFFF_FFFF, 4'hF);
    gexp[0] = impl[0];
    check_all();
    // One-way strap: once set, the lock holds until reset.
    do_reset(1'b1);
    rd_chk(LOCK_OFS, 32'h0000_0002);
    check_all();
    unlock();
    wr_reg(LOCK_OFS, 32'h0000_0001, 4'hF);
    unlock();
    wr_reg(LOCK_OFS, 32'h0000_0000, 4'hF);
    rd_chk(LOCK_OFS, 32'h0000_0003);
    unlock();
    wr_reg(LOCK_OFS + 12'h4, 32'h0000_0001, 4'hF);
    rd_chk(LOCK_OFS, 32'h0000_0003);
    wr_reg(TIMER_OFS, 32'hFFFF_FFFF, 4'hF);
    check_all();
    do_reset(1'b1);
    rd_chk(LOCK_OFS, 32'h0000_0002);
    stop_test();
  end
endmodule
